/* core/afx_pkg.sv */
// Package of constants and carriers for the FIFO host controller
package afx_pkg;
    // Register byte offsets
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_WDATA  = 12'h004;
    localparam logic [11:0] REG_RDATA  = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;
    localparam logic [11:0] REG_WCOUNT = 12'h010;
    // Command bits of the control register
    localparam int CMD_RESET = 0;
    localparam int CMD_WRITE = 1;
    localparam int CMD_READ  = 2;
    localparam int CMD_RETX  = 3;
    // Status bits
    localparam int ST_BUSY    = 0;
    localparam int ST_EMPTY   = 1;
    localparam int ST_FULL    = 2;
    localparam int ST_HALF    = 3;
    localparam int ST_READY   = 4;
    localparam int ST_REFUSED = 5;
    localparam int WORD_W     = 9;
    localparam int SYNC_LAT   = 3;
    // Pin timing in ns
    localparam int CLK_NS   = 10;
    localparam int T_PW_NS  = 30;
    localparam int T_SD_NS  = 18;
    localparam int T_WR_NS  = 10;
    localparam int T_WEF_NS = 30;
    localparam int T_PR_NS  = 30;
    localparam int T_A_NS   = 30;
    localparam int T_RR_NS  = 10;
    localparam int T_RFF_NS = 30;
    localparam int T_RPW_NS = 30;
    localparam int T_PMR_NS = 30;
    localparam int T_RMR_NS = 10;
    localparam int T_EFL_NS = 40;
    localparam int T_PRT_NS = 30;
    localparam int T_RTR_NS = 10;
    localparam int T_RTC_NS = 40;
    // Cycle counts, least times rounded up
    localparam logic [7:0] WR_LOW_CYC = 8'((((T_PW_NS > T_SD_NS) ? T_PW_NS : T_SD_NS)
                                           + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] WR_REC_CYC = 8'((((T_WR_NS > T_WEF_NS) ? T_WR_NS : T_WEF_NS)
                                           + CLK_NS - 1) / CLK_NS + SYNC_LAT);
    localparam logic [7:0] RD_LOW_CYC = 8'((((T_PR_NS > T_A_NS) ? T_PR_NS : T_A_NS)
                                           + CLK_NS - 1) / CLK_NS + SYNC_LAT);
    localparam logic [7:0] RD_REC_CYC = 8'((((T_RR_NS > T_RFF_NS) ? T_RR_NS : T_RFF_NS)
                                           + CLK_NS - 1) / CLK_NS + SYNC_LAT);
    localparam logic [7:0] MR_PRE_CYC = 8'((T_RPW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] MR_LOW_CYC = 8'((T_PMR_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] MR_REC_CYC = 8'((((T_RMR_NS > T_EFL_NS) ? T_RMR_NS : T_EFL_NS)
                                           + CLK_NS - 1) / CLK_NS + SYNC_LAT);
    localparam logic [7:0] RT_LOW_CYC = 8'((T_PRT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] RT_REC_CYC = 8'((((T_RTR_NS > T_RTC_NS) ? T_RTR_NS : T_RTC_NS)
                                           + CLK_NS - 1) / CLK_NS + SYNC_LAT);
    // Pins driven to the FIFO device
    typedef struct packed {
        logic master_reset_n;
        logic store_strobe_n;
        logic fetch_strobe_n;
        logic retransmit_n;
        logic expansion_in_n;
        logic first_load_n;
    } afx_ctl_t;
    localparam afx_ctl_t CTL_RESET = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    // Flags coming back from the FIFO device
    typedef struct packed {
        logic empty_flag_n;
        logic full_flag_n;
        logic half_full_flag_n;
    } afx_flags_t;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_MR_PRE = 4'h1,
        ST_MR_LOW = 4'h2,
        ST_MR_REC = 4'h3,
        ST_WR_LOW = 4'h4,
        ST_WR_REC = 4'h5,
        ST_RD_LOW = 4'h6,
        ST_RD_REC = 4'h7,
        ST_RT_LOW = 4'h8,
        ST_RT_REC = 4'h9
    } afx_state_t;
endpackage : afx_pkg

/* core/afx_host.sv */
// Host controller that drives an asynchronous FIFO device from APB
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [R1] Master reset after power up, flags then valid
// [R2] Strobes held high around master reset release
// [R3] Store strobe falling starts write, word held
// [R4] Full flag low means last location filled
// [R5] No store strobe issued while full
// [R6] Full flag rises after read, waited
// [R7] Empty flag rises after write, waited
// [R8] Half flag low above half capacity
// [R9] Half flag rises after read to half
// [R10] Half flag and retransmit only standalone
// [R11] No fetch strobe issued while empty
// [R12] Output word floats while fetch high
// [R13] Last word read sets empty flag low
// [R14] Retransmit low pulse rewinds read pointer
// [R15] Strobes high during retransmit and recovery
// [R16] Flags recomputed after retransmit, waited
// [R17] Retransmit refused beyond depth writes
// [R18] Standalone: expansion low, first load high
// [R19] Depth chain selected only at reset
// [R20] Expansion output pulses hand over device
// [R21] Host blocks reads empty, writes full
// [R22] Flags valid before next strobe cycle
// [R23] Device pointers wrap circularly
module afx_host
    import afx_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output var  logic [31:0]         prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    output var  afx_ctl_t            fifo_ctl,
    output var  logic [WORD_W-1:0]   input_word,
    input  wire afx_flags_t          fifo_flags,
    input  wire logic [WORD_W-1:0]   output_word
);
    localparam int SW = 3 + WORD_W;

    initial begin
        if (DEPTH < 1 || DEPTH > 4096) begin
            $error("DEPTH out of range");
        end
        if (WORD_W > 23) begin
            $error("WORD_W too wide for register fields");
        end
    end

    // Pin synchroniser
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [SW-1:0] sync3;
    logic [SW-1:0] stable;
    logic [SW-1:0] next_stable;

    always_comb begin
        next_stable = ((sync2 ^ sync3) & stable) | (~(sync2 ^ sync3) & sync3);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1  <= '0;
            sync2  <= '0;
            sync3  <= '0;
            stable <= '0;
        end else begin
            sync1  <= {fifo_flags, output_word};
            sync2  <= sync1;
            sync3  <= sync2;
            stable <= next_stable;
        end
    end

    afx_flags_t flags;
    assign flags = stable[SW-1:WORD_W];

    // Control group
    afx_state_t        state;
    afx_state_t        next_state;
    logic [7:0]        timer;
    logic [7:0]        next_timer;
    afx_ctl_t          next_fifo_ctl;
    logic [WORD_W-1:0] next_input_word;
    logic [WORD_W-1:0] wdata;
    logic [WORD_W-1:0] next_wdata;
    logic [WORD_W-1:0] rdata;
    logic [WORD_W-1:0] next_rdata;
    logic [12:0]       wcount;
    logic [12:0]       next_wcount;
    logic              ready;
    logic              next_ready;
    logic              refused;
    logic              next_refused;
    logic [31:0]       next_prdata;
    logic              next_pready;
    logic              next_pslverr;
    logic              wr_acc;
    logic              mapped;
    logic [31:0]       status;

    always_comb begin
        wr_acc = psel && penable && pready && pwrite;
        mapped = (paddr == REG_CTRL) || (paddr == REG_WDATA) || (paddr == REG_RDATA)
                 || (paddr == REG_STATUS) || (paddr == REG_WCOUNT);
        status = '0;
        status[ST_BUSY]    = (state != ST_IDLE);
        status[ST_EMPTY]   = ~flags.empty_flag_n;
        status[ST_FULL]    = ~flags.full_flag_n;
        status[ST_HALF]    = ~flags.half_full_flag_n; // [R10]
        status[ST_READY]   = ready;
        status[ST_REFUSED] = refused;
        next_state      = state;
        next_timer      = (timer != 8'h00) ? timer - 8'h01 : 8'h00;
        next_fifo_ctl   = fifo_ctl;
        next_input_word = input_word;
        next_wdata      = wdata;
        next_rdata      = rdata;
        next_wcount     = wcount;
        next_ready      = ready;
        next_refused    = refused;
        next_fifo_ctl.expansion_in_n = 1'b0; // [R18]
        next_fifo_ctl.first_load_n   = 1'b1; // [R18] [R19]
        if (wr_acc && paddr == REG_WDATA) begin
            next_wdata = pwdata[WORD_W-1:0];
        end
        if (wr_acc && paddr == REG_STATUS && pwdata[ST_REFUSED]) begin
            next_refused = 1'b0;
        end
        unique case (state)
            ST_IDLE: begin
                if (wr_acc && paddr == REG_CTRL) begin
                    if (pwdata[CMD_RESET]) begin
                        next_state = ST_MR_PRE;
                        next_timer = MR_PRE_CYC;
                    end else if (pwdata[CMD_RETX]) begin
                        if (ready && wcount <= 13'(DEPTH)) begin // [R17]
                            next_state = ST_RT_LOW;
                            next_timer = RT_LOW_CYC;
                            next_fifo_ctl.retransmit_n = 1'b0; // [R14] [R15]
                        end else begin
                            next_refused = 1'b1;
                        end
                    end else if (pwdata[CMD_READ]) begin
                        if (ready && flags.empty_flag_n) begin // [R11] [R21] [R13]
                            next_state = ST_RD_LOW;
                            next_timer = RD_LOW_CYC;
                            next_fifo_ctl.fetch_strobe_n = 1'b0;
                        end else begin
                            next_refused = 1'b1;
                        end
                    end else if (pwdata[CMD_WRITE]) begin
                        if (ready && flags.full_flag_n) begin // [R5] [R21] [R4]
                            next_state = ST_WR_LOW;
                            next_timer = WR_LOW_CYC;
                            next_input_word = wdata; // [R3]
                            next_fifo_ctl.store_strobe_n = 1'b0; // [R3]
                        end else begin
                            next_refused = 1'b1;
                        end
                    end
                end
            end
            ST_MR_PRE: begin
                if (timer == 8'h00) begin // [R2]
                    next_state = ST_MR_LOW;
                    next_timer = MR_LOW_CYC;
                    next_fifo_ctl.master_reset_n = 1'b0; // [R1]
                    next_ready = 1'b0;
                end
            end
            ST_MR_LOW: begin
                if (timer == 8'h00) begin
                    next_state = ST_MR_REC;
                    next_timer = MR_REC_CYC;
                    next_fifo_ctl.master_reset_n = 1'b1;
                end
            end
            ST_MR_REC: begin
                if (timer == 8'h00) begin // [R2] [R1]
                    next_state  = ST_IDLE;
                    next_ready  = 1'b1;
                    next_wcount = 13'h0000;
                end
            end
            ST_WR_LOW: begin
                if (timer == 8'h00) begin
                    next_state = ST_WR_REC;
                    next_timer = WR_REC_CYC;
                    next_fifo_ctl.store_strobe_n = 1'b1; // [R3]
                    if (wcount != 13'h1FFF) begin
                        next_wcount = wcount + 13'h0001;
                    end
                end
            end
            ST_WR_REC: begin
                if (timer == 8'h00) begin // [R7] [R8] [R22] [R23]
                    next_state = ST_IDLE;
                end
            end
            ST_RD_LOW: begin
                if (timer == 8'h00) begin
                    next_state = ST_RD_REC;
                    next_timer = RD_REC_CYC;
                    next_rdata = stable[WORD_W-1:0]; // [R12]
                    next_fifo_ctl.fetch_strobe_n = 1'b1;
                end
            end
            ST_RD_REC: begin
                if (timer == 8'h00) begin // [R6] [R9] [R13] [R22] [R20]
                    next_state = ST_IDLE;
                end
            end
            ST_RT_LOW: begin
                if (timer == 8'h00) begin
                    next_state = ST_RT_REC;
                    next_timer = RT_REC_CYC;
                    next_fifo_ctl.retransmit_n = 1'b1; // [R14]
                end
            end
            ST_RT_REC: begin
                if (timer == 8'h00) begin // [R15] [R16]
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (state != ST_IDLE && wr_acc && paddr == REG_CTRL && pwdata[3:0] != 4'h0) begin
            next_refused = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= ST_MR_PRE;
            timer      <= MR_PRE_CYC;
            fifo_ctl   <= CTL_RESET;
            input_word <= '0;
            wdata      <= '0;
            rdata      <= '0;
            wcount     <= 13'h0000;
            ready      <= 1'b0;
            refused    <= 1'b0;
        end else begin
            state      <= next_state;
            timer      <= next_timer;
            fifo_ctl   <= next_fifo_ctl;
            input_word <= next_input_word;
            wdata      <= next_wdata;
            rdata      <= next_rdata;
            wcount     <= next_wcount;
            ready      <= next_ready;
            refused    <= next_refused;
        end
    end

    // Bus answer group
    always_comb begin
        next_pready  = psel && !penable && !pready;
        next_pslverr = psel && !penable && !pready && !mapped;
        next_prdata  = prdata;
        if (psel && !penable && !pready) begin
            unique case (paddr)
                REG_WDATA:  next_prdata = {23'h00_0000, wdata};
                REG_RDATA:  next_prdata = {23'h00_0000, rdata};
                REG_STATUS: next_prdata = status;
                REG_WCOUNT: next_prdata = {19'h0_0000, wcount};
                default:    next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end
endmodule : afx_host
`default_nettype wire

/* sim/afx_host_checker.sv */
// Port assertions for the FIFO host controller
`timescale 1ns/10ps
`default_nettype none
module afx_host_checker
    import afx_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire afx_ctl_t          fifo_ctl,
    input wire logic [WORD_W-1:0] input_word,
    input wire afx_flags_t        fifo_flags,
    input wire logic [WORD_W-1:0] output_word
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_mr_after_rst: assert property ($rose(presetn) |-> ##[1:8] !fifo_ctl.master_reset_n)
        else $error("device reset not started");
    a_mr_pulse_len: assert property ($fell(fifo_ctl.master_reset_n) |->
        !fifo_ctl.master_reset_n [*4] ##1 fifo_ctl.master_reset_n)
        else $error("device reset pulse length wrong");
    a_mr_strobes_high: assert property ((!fifo_ctl.master_reset_n || $past(!fifo_ctl.master_reset_n))
        |-> fifo_ctl.store_strobe_n && fifo_ctl.fetch_strobe_n)
        else $error("strobe low around device reset");
    a_store_pulse: assert property ($fell(fifo_ctl.store_strobe_n) |->
        !fifo_ctl.store_strobe_n [*4] ##1 fifo_ctl.store_strobe_n)
        else $error("store pulse length wrong");
    a_word_hold: assert property (!$past(fifo_ctl.store_strobe_n) |-> $stable(input_word))
        else $error("word changed during store");
    a_no_store_full: assert property ($fell(fifo_ctl.store_strobe_n) |->
        $past(fifo_flags.full_flag_n))
        else $error("store issued while full");
    a_no_fetch_empty: assert property ($fell(fifo_ctl.fetch_strobe_n) |->
        $past(fifo_flags.empty_flag_n))
        else $error("fetch issued while empty");
    a_fetch_pulse: assert property ($fell(fifo_ctl.fetch_strobe_n) |->
        !fifo_ctl.fetch_strobe_n [*7] ##1 fifo_ctl.fetch_strobe_n)
        else $error("fetch pulse length wrong");
    a_rt_strobes_high: assert property (!fifo_ctl.retransmit_n |->
        fifo_ctl.store_strobe_n && fifo_ctl.fetch_strobe_n)
        else $error("strobe low during retransmit");
    a_standalone_pins: assert property (!fifo_ctl.expansion_in_n && fifo_ctl.first_load_n)
        else $error("expansion pins not standalone");
endmodule : afx_host_checker
`default_nettype wire

/* sim/afx_dev_model.sv */
// Behavioural model of the asynchronous FIFO device
`timescale 1ns/10ps
`default_nettype none
module afx_dev_model
    import afx_pkg::*;
#(
    parameter int D = 4
) (
    input  wire afx_ctl_t          ctl,
    input  wire logic [WORD_W-1:0] din,
    output var  afx_flags_t        flags,
    output var  logic [WORD_W-1:0] dout
);
    logic [WORD_W-1:0] mem [D];
    int                wp = 0;
    int                rp = 0;
    int                cnt = 0;
    int                nwr = 0;
    bit                w_ok;
    bit                r_ok;
    initial flags = 3'b011;
    initial dout = '0;
    always @(negedge ctl.master_reset_n) begin
        wp = 0;
        rp = 0;
        cnt = 0;
        nwr = 0;
        #20 flags = 3'b011;
    end
    always @(negedge ctl.store_strobe_n) begin
        w_ok = flags.full_flag_n;
        if (w_ok) begin
            #20 flags.full_flag_n = (cnt + 1 != D);
            flags.half_full_flag_n = (cnt + 1 <= D / 2);
        end
    end
    always @(posedge ctl.store_strobe_n) if (w_ok) begin
        mem[wp] = din;
        wp = (wp + 1) % D;
        cnt++;
        nwr++;
        #20 flags.empty_flag_n = 1'b1;
    end
    always @(negedge ctl.fetch_strobe_n) begin
        r_ok = flags.empty_flag_n;
        if (r_ok) dout = mem[rp];
        if (r_ok && cnt == 1) #20 flags.empty_flag_n = 1'b0;
    end
    always @(posedge ctl.fetch_strobe_n) begin
        dout = ~dout;
        if (r_ok) begin
            rp = (rp + 1) % D;
            cnt--;
            #20 flags.full_flag_n = 1'b1;
            flags.half_full_flag_n = (cnt <= D / 2);
        end
    end
    always @(negedge ctl.retransmit_n) begin
        rp = 0;
        cnt = (nwr < D) ? nwr : D;
        #20 flags = {cnt != 0, cnt != D, cnt <= D / 2};
    end
endmodule : afx_dev_model
`default_nettype wire

/* sim/tb.sv */
// Self-checking testbench of the FIFO host controller
`timescale 1ns/10ps
`default_nettype none
module tb import afx_pkg::*;;
    localparam int DEPTH = 4;
    logic              pclk = 1'b0;
    logic              presetn, psel, penable, pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, q, seed = 32'd45;
    logic              pready, pslverr;
    afx_ctl_t          fifo_ctl;
    afx_flags_t        fifo_flags;
    logic [WORD_W-1:0] input_word, output_word;
    logic [WORD_W-1:0] w [5];
    logic [33:0]       exp_q [$];
    logic [33:0]       e;
    int                error_cnt = 0;
    int                num_checks = 0;
    always #5 pclk = ~pclk;
    afx_host #(.DEPTH(DEPTH)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fifo_ctl(fifo_ctl), .input_word(input_word),
        .fifo_flags(fifo_flags), .output_word(output_word));
    afx_dev_model #(.D(DEPTH)) i_dev (.ctl(fifo_ctl), .din(input_word), .flags(fifo_flags),
        .dout(output_word));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [32:0] st(int c, int rf);
        return 33'((rf << ST_REFUSED) | (1 << ST_READY) | ((c > DEPTH / 2) << ST_HALF)
            | ((c == DEPTH) << ST_FULL) | ((c == 0) << ST_EMPTY));
    endfunction : st
    task automatic apb(input logic w_n, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w_n;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [11:0] a, input logic [32:0] x);
        exp_q.push_back({1'b1, x});
        apb(1'b0, a, 32'h0000_0000);
    endtask : chk
    task automatic poll(input int b, input logic v);
        for (int i = 0; i < 60; i++) begin
            exp_q.push_back('0);
            apb(1'b0, REG_STATUS, 32'h0000_0000);
            if (q[b] === v) break;
        end
        if (q[b] !== v) begin
            error_cnt++;
            $display("[FAIL] status bit %0d expected %b seen %b", b, v, q[b]);
        end
    endtask : poll
    task automatic cmd(input int c);
        apb(1'b1, REG_CTRL, 32'(c));
        poll(ST_BUSY, 1'b0);
    endtask : cmd
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[33]) begin
                num_checks++;
                if ({pslverr, prdata} !== e[32:0]) begin
                    error_cnt++;
                    $display("[FAIL] addr %h expected %h seen %h", paddr, e[32:0], {pslverr, prdata});
                end
            end
        end
    end
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            poll(ST_READY, 1'b1);
            chk(REG_STATUS, st(0, 0));
            chk(REG_WCOUNT, 33'h0_0000_0000);
            cmd(4);
            chk(REG_STATUS, st(0, 1));
            apb(1'b1, REG_STATUS, 32'h0000_0020);
            for (int i = 0; i < 5; i++) begin
                apb(1'b1, REG_WDATA, xs());
                w[i] = pwdata[8:0];
                cmd(2);
                chk(REG_STATUS, st((i < 4) ? i + 1 : 4, i / 4));
            end
            apb(1'b1, REG_STATUS, 32'h0000_0020);
            chk(12'h040, {1'b1, 32'h0000_0000});
            for (int k = 0; k < 2; k++) begin
                cmd(4);
                chk(REG_RDATA, 33'(w[k]));
                chk(REG_STATUS, st(3 - k, 0));
            end
            cmd(8);
            chk(REG_STATUS, st(4, 0));
            for (int k = 0; k < 4; k++) begin
                cmd(4);
                chk(REG_RDATA, 33'(w[k]));
                chk(REG_STATUS, st(3 - k, 0));
            end
            apb(1'b1, REG_WDATA, xs());
            cmd(2);
            cmd(8);
            chk(REG_STATUS, st(1, 1));
            cmd(1);
            chk(REG_STATUS, st(0, 1));
            chk(REG_WCOUNT, 33'h0_0000_0000);
            presetn <= 1'b0;
            repeat (2) @(posedge pclk);
            presetn <= 1'b1;
        end
        report_and_stop();
    end
endmodule : tb
bind afx_host afx_host_checker #(.DEPTH(DEPTH)) i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fifo_ctl(fifo_ctl),
    .input_word(input_word), .fifo_flags(fifo_flags), .output_word(output_word));
`default_nettype wire
